// File: rtl/fwd_dual_watchdog.sv
// Dual communication watchdog with APB registers and safe output control
//
// What this block does
// - Two independent watchdogs, bus traffic and local interface, default 100 ms.
// - One prescaler register at 0x400 sets the tick for both watchdogs.
// - Own time registers: local at 0x410, bus at 0x420, scaled by prescaler.
// - Tick lasts prescaler plus two 40 ns base periods; timeout is tick times count.
// - Each completed bus process data exchange restarts the bus watchdog.
// - Bus watchdog expires when enabled and idle longer than its timeout.
// - Expiry leaves the communication state machine untouched.
// - Bus watchdog stays expired until the next successful process data access or a bus time of zero.
// - On expiry outputs go to the chosen safe state: off or preset value.
// - Local watchdog expires when enabled and the local side stays idle too long.
// - Bus time of zero disables that watchdog; no forced safe state then.
// - Prescaler and time registers take any value up to 65535.
// - Guarded run state keeps outputs safe; run state copies master output data.
`timescale 1ns/10ps
module fwd_dual_watchdog #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // Bus process data side
  input  wire logic              pd_done,
  input  wire logic [15:0]       pd_out_data,
  input  wire logic              run_state,
  // Local process interface side
  input  wire logic              local_process_interface_access,
  // Outputs and interrupt
  output logic [15:0]            out_data,
  output logic                   out_safe,
  output logic                   irq
);

  typedef struct packed {
    logic [15:0] prescaler;
    logic [15:0] local_time;
    logic [15:0] bus_time;
    logic        safe_preset;
    logic [15:0] safe_value;
    logic [1:0]  irq_stat;
    logic [1:0]  irq_mask;
    logic [1:0]  exp_prev;
    logic [31:0] rd_data;
    logic [15:0] out_data;
    logic        out_safe;
  } fwd_main_st_s;

  fwd_main_st_s          st_reg;
  fwd_main_st_s          st_next;
  fwd_pkg::fwd_wd_stat_s bus_stat;
  fwd_pkg::fwd_wd_stat_s local_stat;
  logic                  wd_tick;
  logic [1:0]            expired;
  logic [1:0]            exp_event;
  logic [11:0]           addr;
  logic                  setup;
  logic                  access;
  logic                  hit;
  logic                  forced;
  logic [31:0]           rd_mux;

  // Byte-lane merge for 16-bit registers
  function automatic logic [15:0] wmerge16(input logic [15:0] old_v,
                                           input logic [31:0] wd,
                                           input logic [3:0]  strb);
    logic [15:0] res;
    res = old_v;
    if (strb[0]) begin
      res[7:0] = wd[7:0];
    end
    if (strb[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction

  // Shared tick and the two watchdogs
  fwd_tick_gen u_tick (
    .pclk      (pclk),
    .presetn   (presetn),
    .prescaler (st_reg.prescaler),
    .tick      (wd_tick)
  );

  fwd_wd_timer u_bus_wd (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (wd_tick),
    .restart (pd_done),
    .wd_time (st_reg.bus_time),
    .stat    (bus_stat)
  );

  fwd_wd_timer u_local_wd (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (wd_tick),
    .restart (local_process_interface_access),
    .wd_time (st_reg.local_time),
    .stat    (local_stat)
  );

  assign expired[fwd_pkg::EXP_BUS_BIT]   = bus_stat.expired;
  assign expired[fwd_pkg::EXP_LOCAL_BIT] = local_stat.expired;
  assign exp_event = expired & ~st_reg.exp_prev;

  // APB decode
  assign addr   = paddr[11:0];
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign hit    = (addr == fwd_pkg::ADDR_PRESCALER)  || (addr == fwd_pkg::ADDR_LOCAL_TIME) ||
                  (addr == fwd_pkg::ADDR_BUS_TIME)   || (addr == fwd_pkg::ADDR_CTRL)       ||
                  (addr == fwd_pkg::ADDR_STATUS)     || (addr == fwd_pkg::ADDR_IRQ_STAT)   ||
                  (addr == fwd_pkg::ADDR_IRQ_MASK)   || (addr == fwd_pkg::ADDR_SAFE_VALUE);

  assign pready  = 1'b1;
  assign pslverr = access && !hit;
  assign prdata  = st_reg.rd_data;

  always_comb begin
    rd_mux = 32'h00000000;
    case (addr)
      fwd_pkg::ADDR_PRESCALER:  rd_mux[15:0] = st_reg.prescaler;
      fwd_pkg::ADDR_LOCAL_TIME: rd_mux[15:0] = st_reg.local_time;
      fwd_pkg::ADDR_BUS_TIME:   rd_mux[15:0] = st_reg.bus_time;
      fwd_pkg::ADDR_CTRL:       rd_mux[fwd_pkg::CTRL_SAFE_PRESET_BIT] = st_reg.safe_preset;
      fwd_pkg::ADDR_STATUS:     rd_mux[1:0] = expired;
      fwd_pkg::ADDR_IRQ_STAT:   rd_mux[1:0] = st_reg.irq_stat;
      fwd_pkg::ADDR_IRQ_MASK:   rd_mux[1:0] = st_reg.irq_mask;
      fwd_pkg::ADDR_SAFE_VALUE: rd_mux[15:0] = st_reg.safe_value;
      default:                  rd_mux = 32'h00000000;
    endcase
  end

  // Forced safe output: any enabled watchdog expired, or guarded run state
  assign forced = (|expired) || !run_state;

  always_comb begin
    st_next = st_reg;
    st_next.exp_prev = expired;
    if (setup) begin
      st_next.rd_data = rd_mux;
    end
    // Settings change only on writes; nothing reloads them otherwise
    if (access && pwrite) begin
      case (addr)
        fwd_pkg::ADDR_PRESCALER: begin
          st_next.prescaler = wmerge16(st_reg.prescaler, pwdata, pstrb);
        end
        fwd_pkg::ADDR_LOCAL_TIME: begin
          st_next.local_time = wmerge16(st_reg.local_time, pwdata, pstrb);
        end
        fwd_pkg::ADDR_BUS_TIME: begin
          st_next.bus_time = wmerge16(st_reg.bus_time, pwdata, pstrb);
        end
        fwd_pkg::ADDR_CTRL: begin
          if (pstrb[0]) begin
            st_next.safe_preset = pwdata[fwd_pkg::CTRL_SAFE_PRESET_BIT];
          end
        end
        fwd_pkg::ADDR_IRQ_MASK: begin
          if (pstrb[0]) begin
            st_next.irq_mask = pwdata[1:0];
          end
        end
        fwd_pkg::ADDR_SAFE_VALUE: begin
          st_next.safe_value = wmerge16(st_reg.safe_value, pwdata, pstrb);
        end
        default: begin
          st_next.irq_mask = st_reg.irq_mask;
        end
      endcase
    end
    // Read clears only the bits it returned; a new event wins
    if (access && !pwrite && addr == fwd_pkg::ADDR_IRQ_STAT) begin
      st_next.irq_stat = st_reg.irq_stat & ~st_reg.rd_data[1:0];
    end
    st_next.irq_stat = st_next.irq_stat | exp_event;
    // Output stage; the communication state is only read here
    if (forced) begin
      st_next.out_safe = 1'b1;
      st_next.out_data = st_reg.safe_preset ? st_reg.safe_value : 16'h0000;
    end else begin
      st_next.out_safe = 1'b0;
      if (pd_done) begin
        st_next.out_data = pd_out_data;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{prescaler:   fwd_pkg::RST_PRESCALER,
                  local_time:  fwd_pkg::RST_LOCAL_TIME,
                  bus_time:    fwd_pkg::RST_BUS_TIME,
                  safe_preset: fwd_pkg::RST_SAFE_PRESET,
                  safe_value:  fwd_pkg::RST_SAFE_VALUE,
                  irq_stat:    2'h0,
                  irq_mask:    fwd_pkg::RST_IRQ_MASK,
                  exp_prev:    2'h0,
                  rd_data:     32'h00000000,
                  out_data:    16'h0000,
                  out_safe:    1'b1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign out_data = st_reg.out_data;
  assign out_safe = st_reg.out_safe;
  assign irq      = |(st_reg.irq_stat & st_reg.irq_mask);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_prescaler_write;
    access && pwrite && addr == fwd_pkg::ADDR_PRESCALER && pstrb[1:0] == 2'h3
      |=> st_reg.prescaler == $past(pwdata[15:0]);
  endproperty
  a_prescaler_write: assert property (p_prescaler_write) else $error("Prescaler not stored");

  property p_bus_time_write;
    access && pwrite && addr == fwd_pkg::ADDR_BUS_TIME && pstrb[1:0] == 2'h3
      |=> st_reg.bus_time == $past(pwdata[15:0]) ##1 $stable(st_reg.bus_time) || $past(access);
  endproperty
  a_bus_time_write: assert property (p_bus_time_write) else $error("Bus time not stored");

  property p_safe_on_expiry;
    bus_stat.expired |=> out_safe &&
      out_data == ($past(st_reg.safe_preset) ? $past(st_reg.safe_value) : 16'h0000);
  endproperty
  a_safe_on_expiry: assert property (p_safe_on_expiry) else $error("Expiry not safe");

  property p_disabled_never_expires;
    st_reg.bus_time == 16'h0000 && $past(st_reg.bus_time) == 16'h0000 |-> !bus_stat.expired;
  endproperty
  a_disabled_never_expires: assert property (p_disabled_never_expires) else
    $error("Disabled watchdog expired");

  property p_guarded_safe;
    !run_state |=> out_safe;
  endproperty
  a_guarded_safe: assert property (p_guarded_safe) else $error("Guarded state not safe");

  property p_run_copy;
    !forced && pd_done |=> !out_safe && out_data == $past(pd_out_data);
  endproperty
  a_run_copy: assert property (p_run_copy) else $error("Run data not copied");

  property p_local_irq;
    local_stat.expired && !$past(local_stat.expired) |=> st_reg.irq_stat[fwd_pkg::EXP_LOCAL_BIT];
  endproperty
  a_local_irq: assert property (p_local_irq) else $error("Local expiry event lost");

  property p_status_read;
    setup && !pwrite && addr == fwd_pkg::ADDR_STATUS |=> prdata[1:0] == $past(expired);
  endproperty
  a_status_read: assert property (p_status_read) else $error("Expired flags misread");

  property p_local_wr;
    access && pwrite && addr == fwd_pkg::ADDR_LOCAL_TIME && pstrb[1:0] == 2'h3
      |=> st_reg.local_time == $past(pwdata[15:0]);
  endproperty
  a_local_wr: assert property (p_local_wr) else $error("Local time not stored");

  property p_safe_val_wr;
    access && pwrite && addr == fwd_pkg::ADDR_SAFE_VALUE && pstrb[1:0] == 2'h3
      |=> st_reg.safe_value == $past(pwdata[15:0]);
  endproperty
  a_safe_val_wr: assert property (p_safe_val_wr) else $error("Safe value not stored");

  property p_ctrl_wr;
    access && pwrite && addr == fwd_pkg::ADDR_CTRL && pstrb[0]
      |=> st_reg.safe_preset == $past(pwdata[fwd_pkg::CTRL_SAFE_PRESET_BIT]);
  endproperty
  a_ctrl_wr: assert property (p_ctrl_wr) else $error("Safe mode not stored");

  property p_irq_event;
    exp_event[fwd_pkg::EXP_BUS_BIT] && st_reg.irq_mask[fwd_pkg::EXP_BUS_BIT] &&
      !(access && pwrite && addr == fwd_pkg::ADDR_IRQ_MASK) |=> irq;
  endproperty
  a_irq_event: assert property (p_irq_event) else $error("Unmasked expiry gave no irq");

  property p_event_wins;
    exp_event[fwd_pkg::EXP_BUS_BIT] |=> st_reg.irq_stat[fwd_pkg::EXP_BUS_BIT];
  endproperty
  a_event_wins: assert property (p_event_wins) else $error("Bus expiry event lost");

  property p_read_clear;
    access && !pwrite && addr == fwd_pkg::ADDR_IRQ_STAT && exp_event == 2'h0
      |=> (st_reg.irq_stat & $past(st_reg.rd_data[1:0])) == 2'h0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Read left event set");

  property p_settings_hold;
    !(access && pwrite) |=> $stable(st_reg.prescaler) && $stable(st_reg.local_time) &&
      $stable(st_reg.bus_time);
  endproperty
  a_settings_hold: assert property (p_settings_hold) else $error("Setting changed alone");

  property p_out_hold;
    !forced && !pd_done |=> !out_safe && $stable(out_data);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("Output data not held");

  property p_forced_safe;
    forced |=> out_safe;
  endproperty
  a_forced_safe: assert property (p_forced_safe) else $error("Forced state not safe");

  property p_unforced_live;
    !(|expired) && run_state |=> !out_safe;
  endproperty
  a_unforced_live: assert property (p_unforced_live) else $error("Safe without cause");

  property p_bus_zero;
    st_reg.bus_time == 16'h0000 |=> !bus_stat.expired;
  endproperty
  a_bus_zero: assert property (p_bus_zero) else $error("Zero bus time kept expiry");

  property p_local_zero;
    st_reg.local_time == 16'h0000 |=> !local_stat.expired;
  endproperty
  a_local_zero: assert property (p_local_zero) else $error("Zero local time kept expiry");

  property p_upper_zero;
    access && !pwrite |-> prdata[31:16] == 16'h0000;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("Upper read bits not zero");

  c_bus_expiry:   cover property (bus_stat.running ##1 bus_stat.expired);
  c_local_expiry: cover property (local_stat.running ##1 local_stat.expired);
  c_irq:          cover property (!irq ##1 irq);
  c_recover:      cover property (bus_stat.expired ##1 pd_done ##1 !bus_stat.expired);

endmodule

// File: rtl/fwd_pkg.sv
// Package: register map, reset values, timing and shared types of the dual watchdog
package fwd_pkg;

  // Register byte offsets
  localparam logic [11:0] ADDR_PRESCALER  = 12'h400;
  localparam logic [11:0] ADDR_LOCAL_TIME = 12'h410;
  localparam logic [11:0] ADDR_BUS_TIME   = 12'h420;
  localparam logic [11:0] ADDR_CTRL       = 12'h430;
  localparam logic [11:0] ADDR_STATUS     = 12'h434;
  localparam logic [11:0] ADDR_IRQ_STAT   = 12'h438;
  localparam logic [11:0] ADDR_IRQ_MASK   = 12'h43C;
  localparam logic [11:0] ADDR_SAFE_VALUE = 12'h440;

  // Reset values
  localparam logic [15:0] RST_PRESCALER  = 16'h09C2;
  localparam logic [15:0] RST_LOCAL_TIME = 16'h03E8;
  localparam logic [15:0] RST_BUS_TIME   = 16'h03E8;
  localparam logic        RST_SAFE_PRESET = 1'b0;
  localparam logic [15:0] RST_SAFE_VALUE = 16'h0000;
  localparam logic [1:0]  RST_IRQ_MASK   = 2'h0;

  // Field positions
  localparam int CTRL_SAFE_PRESET_BIT = 0;
  localparam int EXP_BUS_BIT          = 0;
  localparam int EXP_LOCAL_BIT        = 1;

  // Timing
  localparam int CLK_PERIOD_NS  = 20;
  localparam int BASE_PERIOD_NS = 40;
  localparam int BASE_CYC = (BASE_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [16:0] TICK_OFFSET = 17'h00002;

  // Watchdog states
  typedef enum logic [2:0] {
    WD_OFF = 3'b001,
    WD_RUN = 3'b010,
    WD_EXP = 3'b100
  } fwd_wd_state_e;

  // Watchdog status carried to the register block
  typedef struct packed {
    logic expired;
    logic running;
  } fwd_wd_stat_s;

endpackage

// File: rtl/fwd_tick_gen.sv
// Watchdog tick generator: 40 ns base ticks divided by prescaler plus two
`timescale 1ns/10ps
module fwd_tick_gen (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Setting and tick
  input  wire logic [15:0] prescaler,
  output logic             tick
);

  typedef struct packed {
    logic [7:0]  base_cnt;
    logic [16:0] tick_cnt;
  } fwd_tick_st_s;

  fwd_tick_st_s st_reg;
  fwd_tick_st_s st_next;
  logic         base_en;
  logic [16:0]  last_cnt;

  assign base_en  = (st_reg.base_cnt == 8'(fwd_pkg::BASE_CYC - 1));
  assign last_cnt = {1'b0, prescaler} + fwd_pkg::TICK_OFFSET - 17'h00001;
  assign tick     = base_en && (st_reg.tick_cnt == last_cnt);

  always_comb begin
    st_next = st_reg;
    st_next.base_cnt = base_en ? 8'h00 : st_reg.base_cnt + 8'h01;
    if (base_en) begin
      // Lowered prescaler restarts the count without a tick
      st_next.tick_cnt = (st_reg.tick_cnt >= last_cnt) ? 17'h00000
                                                         : st_reg.tick_cnt + 17'h00001;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_tick_base;
    tick |-> base_en && st_reg.tick_cnt == last_cnt;
  endproperty
  a_tick_base: assert property (p_tick_base) else $error("Tick off its base count");

  property p_base_rate;
    base_en |=> !base_en ##1 base_en;
  endproperty
  a_base_rate: assert property (p_base_rate) else $error("Base tick not every 40 ns");

endmodule

// File: rtl/fwd_wd_timer.sv
// One watchdog: counts ticks since the last restart and flags expiry
`timescale 1ns/10ps
module fwd_wd_timer (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // Timing inputs
  input  wire logic                 tick,
  input  wire logic                 restart,
  input  wire logic [15:0]          wd_time,
  // Status
  output fwd_pkg::fwd_wd_stat_s     stat
);

  typedef struct packed {
    fwd_pkg::fwd_wd_state_e state;
    logic [15:0]            cnt;
  } fwd_wd_st_s;

  fwd_wd_st_s st_reg;
  fwd_wd_st_s st_next;
  logic       hit;

  // Time lowered below the count expires at the next tick
  assign hit = tick && (st_reg.cnt >= wd_time - 16'h0001);

  always_comb begin
    st_next = st_reg;
    if (wd_time == 16'h0000) begin
      st_next.state = fwd_pkg::WD_OFF;
      st_next.cnt   = 16'h0000;
    end else if (restart) begin
      st_next.state = fwd_pkg::WD_RUN;
      st_next.cnt   = 16'h0000;
    end else begin
      case (st_reg.state)
        fwd_pkg::WD_OFF: begin
          st_next.state = fwd_pkg::WD_RUN;
          st_next.cnt   = 16'h0000;
        end
        fwd_pkg::WD_RUN: begin
          if (hit) begin
            st_next.state = fwd_pkg::WD_EXP;
          end else if (tick) begin
            st_next.cnt = st_reg.cnt + 16'h0001;
          end
        end
        fwd_pkg::WD_EXP: begin
          st_next.state = fwd_pkg::WD_EXP;
        end
        default: begin
          st_next.state = fwd_pkg::WD_OFF;
          st_next.cnt   = 16'h0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= '{state: fwd_pkg::WD_OFF, cnt: 16'h0000};
    end else begin
      st_reg <= st_next;
    end
  end

  assign stat.expired = (st_reg.state == fwd_pkg::WD_EXP);
  assign stat.running = (st_reg.state == fwd_pkg::WD_RUN);

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_restart_clears;
    restart |=> !stat.expired;
  endproperty
  a_restart_clears: assert property (p_restart_clears) else $error("Restart left expiry");

  property p_expiry_holds;
    stat.expired && !restart && wd_time != 16'h0000 |=> stat.expired;
  endproperty
  a_expiry_holds: assert property (p_expiry_holds) else $error("Expiry dropped alone");

  property p_trigger;
    stat.running && hit && !restart && wd_time != 16'h0000 |=> stat.expired;
  endproperty
  a_trigger: assert property (p_trigger) else $error("Timeout not flagged");

endmodule

// File: test/fwd_far_side.sv
// Far-side model: bus master process data and local processor accesses
`timescale 1ns/10ps
module fwd_far_side #(
  parameter int PERIOD = 3
) (
  // Clock and reset
  input  wire logic   pclk,
  input  wire logic   presetn,
  // Traffic enables
  input  wire logic   pd_en,
  input  wire logic   local_en,
  // Process data and local access
  output logic        pd_done,
  output logic [15:0] pd_out_data,
  output logic        local_process_interface_access
);
  int          cnt;
  logic [15:0] data;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      data <= 16'h1234;
      pd_done <= 1'b0;
      pd_out_data <= 16'hEDCB;
      local_process_interface_access <= 1'b0;
    end else begin
      cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
      pd_done <= pd_en && (cnt == 0);
      local_process_interface_access <= local_en && (cnt == 1);
      if (pd_en && (cnt == 0)) begin
        data <= data + 16'h0101;
        pd_out_data <= data + 16'h0101;
      end else begin
        // Data only valid with the done pulse
        pd_out_data <= ~pd_out_data;
      end
    end
  end
endmodule

// File: test/fwd_dual_watchdog_tb_top.sv
// Testbench: register access and watchdog expiry scenarios for the dual watchdog
`timescale 1ns/10ps
module fwd_dual_watchdog_tb_top;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [3:0]  pstrb;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        pd_done;
  logic [15:0] pd_out_data;
  logic        run_state;
  logic        local_access;
  logic [15:0] out_data;
  logic        out_safe;
  logic        irq;
  logic        pd_en;
  logic        local_en;
  logic [15:0] last_pd;
  logic [31:0] rd;
  logic        err;
  int          n_fail;
  int          comparisons;

  fwd_dual_watchdog u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pd_done(pd_done), .pd_out_data(pd_out_data),
    .run_state(run_state), .local_process_interface_access(local_access),
    .out_data(out_data), .out_safe(out_safe), .irq(irq)
  );

  fwd_far_side u_far (
    .pclk(pclk), .presetn(presetn), .pd_en(pd_en), .local_en(local_en),
    .pd_done(pd_done), .pd_out_data(pd_out_data),
    .local_process_interface_access(local_access)
  );

  always #10 pclk = ~pclk;

  always @(posedge pclk) begin
    if (pd_done) begin
      last_pd <= pd_out_data;
    end
  end

  task automatic complete_run;
    if (n_fail == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0000_0000);
    chk(rd, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    complete_run();
  end

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    pstrb = 4'hF;
    run_state = 1'b1;
    pd_en = 1'b1;
    local_en = 1'b1;
    n_fail = 0;
    comparisons = 0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(fwd_pkg::ADDR_PRESCALER, 32'h0000_09C2);
    chk(err, 1'b0);
    rd_chk(fwd_pkg::ADDR_LOCAL_TIME, 32'h0000_03E8);
    rd_chk(fwd_pkg::ADDR_BUS_TIME, 32'h0000_03E8);
    rd_chk(12'h7F0, 32'h0000_0000);
    chk(err, 1'b1);
    apb(fwd_pkg::ADDR_PRESCALER, 1'b1, 32'h0000_FFFF);
    rd_chk(fwd_pkg::ADDR_PRESCALER, 32'h0000_FFFF);
    apb(fwd_pkg::ADDR_PRESCALER, 1'b1, 32'h0000_0000);
    apb(fwd_pkg::ADDR_LOCAL_TIME, 1'b1, 32'h0000_0003);
    apb(fwd_pkg::ADDR_BUS_TIME, 1'b1, 32'h0000_0003);
    rd_chk(fwd_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    // Steady traffic keeps both watchdogs quiet
    pd_en <= 1'b1;
    local_en <= 1'b1;
    idle(40);
    chk(out_safe, 1'b0);
    chk(out_data, last_pd);
    rd_chk(fwd_pkg::ADDR_STATUS, 32'h0000_0000);
    // Bus traffic stops: expiry, safe off, masked interrupt
    pd_en <= 1'b0;
    idle(7);
    chk(out_safe, 1'b0);
    idle(11);
    chk(out_safe, 1'b1);
    idle(22);
    chk(out_safe, 1'b1);
    chk(out_data, 16'h0000);
    chk(irq, 1'b0);
    rd_chk(fwd_pkg::ADDR_STATUS, 32'h0000_0001);
    apb(fwd_pkg::ADDR_IRQ_MASK, 1'b1, 32'h0000_0003);
    idle(1);
    chk(irq, 1'b1);
    rd_chk(fwd_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    idle(1);
    chk(irq, 1'b0);
    rd_chk(fwd_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    idle(40);
    rd_chk(fwd_pkg::ADDR_STATUS, 32'h0000_0001);
    pd_en <= 1'b1;
    idle(10);
    rd_chk(fwd_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(out_safe, 1'b0);
    // Preset safe value on expiry
    apb(fwd_pkg::ADDR_CTRL, 1'b1, 32'h0000_0001);
    apb(fwd_pkg::ADDR_SAFE_VALUE, 1'b1, 32'h0000_A5C3);
    pd_en <= 1'b0;
    idle(40);
    chk(out_data, 16'hA5C3);
    chk(irq, 1'b1);
    rd_chk(fwd_pkg::ADDR_IRQ_STAT, 32'h0000_0001);
    pd_en <= 1'b1;
    idle(10);
    chk(out_data, last_pd);
    // Local side goes quiet
    local_en <= 1'b0;
    idle(40);
    rd_chk(fwd_pkg::ADDR_STATUS, 32'h0000_0002);
    chk(out_safe, 1'b1);
    local_en <= 1'b1;
    idle(10);
    rd_chk(fwd_pkg::ADDR_STATUS, 32'h0000_0000);
    rd_chk(fwd_pkg::ADDR_IRQ_STAT, 32'h0000_0002);
    // Zero bus time disables the bus watchdog
    apb(fwd_pkg::ADDR_BUS_TIME, 1'b1, 32'h0000_0000);
    pd_en <= 1'b0;
    idle(80);
    rd_chk(fwd_pkg::ADDR_STATUS, 32'h0000_0000);
    chk(out_safe, 1'b0);
    rd_chk(fwd_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
    // Guarded run state forces outputs safe
    run_state <= 1'b0;
    idle(3);
    chk(out_safe, 1'b1);
    @(posedge pclk);
    run_state <= 1'b1;
    idle(3);
    chk(out_safe, 1'b0);
    // Reset in mid-run restores the defaults
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(fwd_pkg::ADDR_BUS_TIME, 32'h0000_03E8);
    rd_chk(fwd_pkg::ADDR_CTRL, 32'h0000_0000);
    chk(out_safe, 1'b0);
    complete_run();
  end
endmodule
